/* src/cbu_branch_unit.sv */
// Conditional branch unit: executes branch-if-not-negative, branch-if-no-overflow
// and branch-if-nonzero. Assumes the fetch unit presents the instruction word and
// the already incremented program counter stable for a whole instruction cycle,
// and that status flags come from same-clock core logic.
// Function
// RQ1 - Not-negative branch taken when negative flag clear
// RQ2 - Decode upper byte E7 as not-negative
// RQ3 - Decode upper byte E5 as no-overflow
// RQ4 - No-overflow taken when overflow flag clear
// RQ5 - Target is incremented counter plus doubled offset
// RQ6 - Overflow set: counter stays at address plus two
// RQ7 - Decode E1 as nonzero; taken when zero clear
// RQ8 - One cycle untaken, two cycles taken
// RQ9 - Taken: decode, read, process, write counter
// RQ10 - Second taken cycle does nothing
// RQ11 - Untaken: no counter write in phase four
// RQ12 - Flags untouched; offset sign-extended before doubling
`include "cbu_defs.svh"
module cbu_branch_unit #(
  parameter int PC_WIDTH = `CBU_PC_WIDTH
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  valid_in,
  input  wire logic [15:0]           instr_in,
  input  wire logic [PC_WIDTH-1:0]   pc_inc_in,
  input  cbu_pkg::cbu_flags_t        flags_in,
  output cbu_pkg::cbu_phase_t        phase_out,
  output logic                       is_branch_out,
  output logic                       busy_out,
  output logic                       pc_write_out,
  output logic [PC_WIDTH-1:0]        pc_target_out,
  output logic                       done_out,
  output logic                       taken_out
);
  typedef struct packed {
    cbu_pkg::cbu_state_t  state;
    logic                 is_branch;
    logic                 taken;
    logic [7:0]           offset;
    logic [PC_WIDTH-1:0]  base;
    logic [PC_WIDTH-1:0]  target;
    logic                 pc_write;
    logic                 done;
  } cbu_core_t;

  cbu_core_t           core_reg;
  cbu_core_t           core_next;
  cbu_pkg::cbu_phase_t phase;
  cbu_pkg::cbu_decode_t dec;
  logic                cond_met;
  logic [PC_WIDTH-1:0] disp;

  cbu_phase_gen u_phase (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .phase_out (phase)
  );

  // Upper byte is prefix nibble then condition nibble; low byte is the offset.
  always_comb begin
    dec.not_neg = valid_in && instr_in[15:12] == `CBU_OP_PREFIX && instr_in[11:8] == `CBU_OP_NOT_NEG; // RQ2
    dec.no_ovf  = valid_in && instr_in[15:12] == `CBU_OP_PREFIX && instr_in[11:8] == `CBU_OP_NO_OVF;  // RQ3
    dec.nonzero = valid_in && instr_in[15:12] == `CBU_OP_PREFIX && instr_in[11:8] == `CBU_OP_NONZERO; // RQ7
  end

  // Flags are only read here; this unit has no path that writes status.
  assign cond_met = (dec.not_neg && !flags_in.negative)   // RQ1
                  || (dec.no_ovf && !flags_in.overflow)   // RQ4 RQ6
                  || (dec.nonzero && !flags_in.zero);     // RQ7 RQ12

  // Sign-extend first, then double, so negative offsets reach backward. RQ12
  assign disp = {{(PC_WIDTH-9){core_reg.offset[7]}}, core_reg.offset, 1'b0}; // RQ5

  always_comb begin
    core_next          = core_reg;
    core_next.pc_write = 1'b0;
    core_next.done     = 1'b0;
    case (core_reg.state)
      cbu_pkg::CBU_EXEC: begin
        case (phase)
          cbu_pkg::CBU_Q1: begin
            core_next.is_branch = dec.not_neg || dec.no_ovf || dec.nonzero; // RQ9
            core_next.taken     = cond_met;
          end
          cbu_pkg::CBU_Q2: begin
            core_next.offset = instr_in[7:0]; // RQ9
            core_next.base   = pc_inc_in;
          end
          cbu_pkg::CBU_Q3: begin
            core_next.target = core_reg.base + disp; // RQ5
          end
          cbu_pkg::CBU_Q4: begin
            if (core_reg.is_branch) begin
              core_next.pc_write = core_reg.taken; // RQ9 RQ11
              core_next.done     = !core_reg.taken; // RQ8
              if (core_reg.taken) begin
                core_next.state = cbu_pkg::CBU_IDLE; // RQ10
              end
            end
          end
          default: core_next.state = cbu_pkg::CBU_EXEC;
        endcase
      end
      cbu_pkg::CBU_IDLE: begin
        // Dead cycle while the fetched follower is discarded. RQ10
        if (phase == cbu_pkg::CBU_Q4) begin
          core_next.state     = cbu_pkg::CBU_EXEC;
          core_next.done      = 1'b1; // RQ8
          core_next.is_branch = 1'b0;
        end
      end
      default: core_next.state = cbu_pkg::CBU_EXEC;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      core_reg <= '{state: cbu_pkg::CBU_EXEC, is_branch: 1'b0, taken: 1'b0, offset: 8'h00,
                    base: '0, target: '0, pc_write: 1'b0, done: 1'b0};
    end else begin
      core_reg <= core_next;
    end
  end

  assign phase_out     = phase;
  assign is_branch_out = core_reg.is_branch;
  assign busy_out      = core_reg.state == cbu_pkg::CBU_IDLE;
  assign pc_write_out  = core_reg.pc_write;
  assign pc_target_out = core_reg.target;
  assign done_out      = core_reg.done;
  assign taken_out     = core_reg.taken;

  sequence s_write;
    pc_write_out;
  endsequence
  sequence s_idle_cycle;
    busy_out [*4];
  endsequence

  AST_TAKEN_IDLE: assert property (@(posedge clk_in) disable iff (rst_in) // RQ10
    s_write |-> s_idle_cycle ##1 done_out)
    else $error("taken branch did not idle one full cycle");
  AST_WRITE_PHASE: assert property (@(posedge clk_in) disable iff (rst_in) // RQ9
    pc_write_out |-> $past(phase) == cbu_pkg::CBU_Q4 && taken_out)
    else $error("counter written outside phase four or untaken");
  AST_UNTAKEN: assert property (@(posedge clk_in) disable iff (rst_in) // RQ11
    done_out && !busy_out && !$past(busy_out) |-> !taken_out && !pc_write_out)
    else $error("untaken branch wrote counter");
  AST_TARGET: assert property (@(posedge clk_in) disable iff (rst_in) // RQ5
    pc_write_out |-> pc_target_out == PC_WIDTH'($past(pc_inc_in, 3)
      + {{(PC_WIDTH-9){$past(instr_in[7], 3)}}, $past(instr_in[7:0], 3), 1'b0}))
    else $error("branch target wrong");
  AST_NOT_NEG: assert property (@(posedge clk_in) disable iff (rst_in) // RQ1
    phase == cbu_pkg::CBU_Q1 && core_reg.state == cbu_pkg::CBU_EXEC && dec.not_neg
    |=> taken_out == !$past(flags_in.negative))
    else $error("not-negative condition wrong");
  AST_NO_OVF: assert property (@(posedge clk_in) disable iff (rst_in) // RQ4
    phase == cbu_pkg::CBU_Q1 && core_reg.state == cbu_pkg::CBU_EXEC && dec.no_ovf
    |=> taken_out == !$past(flags_in.overflow))
    else $error("no-overflow condition wrong");
  AST_OVF_SET: assert property (@(posedge clk_in) disable iff (rst_in) // RQ6
    phase == cbu_pkg::CBU_Q1 && core_reg.state == cbu_pkg::CBU_EXEC && dec.no_ovf && flags_in.overflow
    |-> ##4 done_out && !pc_write_out)
    else $error("overflow set but branch not skipped");
  AST_NONZERO: assert property (@(posedge clk_in) disable iff (rst_in) // RQ7
    phase == cbu_pkg::CBU_Q1 && core_reg.state == cbu_pkg::CBU_EXEC && dec.nonzero && !flags_in.zero
    |-> ##4 pc_write_out)
    else $error("nonzero branch not taken");
  AST_ONE_CYCLE: assert property (@(posedge clk_in) disable iff (rst_in) // RQ8
    phase == cbu_pkg::CBU_Q1 && core_reg.state == cbu_pkg::CBU_EXEC && (dec.not_neg || dec.no_ovf || dec.nonzero)
    && !cond_met |-> ##4 done_out ##1 !busy_out)
    else $error("untaken branch not one cycle");

  // Pulses last exactly one clock so the fetch unit never loads the counter twice.
  AST_DONE_PULSE: assert property (@(posedge clk_in) disable iff (rst_in) // RQ8
    done_out |=> !done_out)
    else $error("done held longer than one clock");
  AST_WRITE_PULSE: assert property (@(posedge clk_in) disable iff (rst_in) // RQ9
    pc_write_out |=> !pc_write_out)
    else $error("counter write held longer than one clock");

  // The target must stand through the idle cycle; nothing recomputes it there.
  AST_TARGET_HOLD: assert property (@(posedge clk_in) disable iff (rst_in) // RQ5
    pc_write_out |=> $stable(pc_target_out))
    else $error("target moved right after the write");

  // The idle cycle starts on the edge that writes the counter, in phase one.
  AST_BUSY_START: assert property (@(posedge clk_in) disable iff (rst_in) // RQ10
    $rose(busy_out) |-> pc_write_out && phase == cbu_pkg::CBU_Q1)
    else $error("idle cycle started without a counter write");
  AST_IDLE_QUIET: assert property (@(posedge clk_in) disable iff (rst_in) // RQ10
    busy_out && $past(busy_out) |-> !pc_write_out && !done_out)
    else $error("activity during the idle cycle");
  AST_TAKEN_HELD: assert property (@(posedge clk_in) disable iff (rst_in) // RQ8
    busy_out |-> taken_out && is_branch_out)
    else $error("idle cycle without a taken branch");
  AST_PHASE_ONEHOT: assert property (@(posedge clk_in) disable iff (rst_in) // RQ9
    $onehot(phase))
    else $error("phase not one-hot");

  // Words outside the three encodings must leave the counter and done alone.
  AST_NON_BRANCH: assert property (@(posedge clk_in) disable iff (rst_in) // RQ2 RQ3 RQ7
    phase == cbu_pkg::CBU_Q1 && core_reg.state == cbu_pkg::CBU_EXEC && !(dec.not_neg || dec.no_ovf || dec.nonzero)
    |-> ##4 !pc_write_out && !done_out)
    else $error("non-branch word produced a branch result");

  // Each condition is checked both ways so a swapped flag bit is caught.
  AST_NOT_NEG_TAKEN: assert property (@(posedge clk_in) disable iff (rst_in) // RQ1
    phase == cbu_pkg::CBU_Q1 && core_reg.state == cbu_pkg::CBU_EXEC && dec.not_neg && !flags_in.negative
    |-> ##4 pc_write_out)
    else $error("not-negative branch not taken");
  AST_NOT_NEG_SET: assert property (@(posedge clk_in) disable iff (rst_in) // RQ1 RQ11
    phase == cbu_pkg::CBU_Q1 && core_reg.state == cbu_pkg::CBU_EXEC && dec.not_neg && flags_in.negative
    |-> ##4 done_out && !pc_write_out)
    else $error("negative set but branch not skipped");
  AST_NO_OVF_TAKEN: assert property (@(posedge clk_in) disable iff (rst_in) // RQ4
    phase == cbu_pkg::CBU_Q1 && core_reg.state == cbu_pkg::CBU_EXEC && dec.no_ovf && !flags_in.overflow
    |-> ##4 pc_write_out)
    else $error("no-overflow branch not taken");
  AST_ZERO_SET: assert property (@(posedge clk_in) disable iff (rst_in) // RQ7 RQ11
    phase == cbu_pkg::CBU_Q1 && core_reg.state == cbu_pkg::CBU_EXEC && dec.nonzero && flags_in.zero
    |-> ##4 done_out && !pc_write_out)
    else $error("zero set but branch not skipped");
endmodule

/* inc/cbu_defs.svh */
// Constants for the conditional branch unit: encodings, widths, phase count.
// Assumes inclusion by bare name from the package and design files.
`ifndef CBU_DEFS_SVH
`define CBU_DEFS_SVH
`define CBU_OP_PREFIX     4'hE
`define CBU_OP_NOT_NEG    4'h7
`define CBU_OP_NO_OVF     4'h5
`define CBU_OP_NONZERO    4'h1
`define CBU_PC_WIDTH      21
`define CBU_PC_STEP       21'h000002
`define CBU_PC_RESET      21'h000000
`define CBU_PHASES        4
`endif

/* inc/cbu_pkg.sv */
// Types shared by the conditional branch unit files.
// Assumes cbu_defs.svh is on the include path.
`include "cbu_defs.svh"
package cbu_pkg;
  typedef enum logic [3:0] {
    CBU_Q1 = 4'h1,
    CBU_Q2 = 4'h2,
    CBU_Q3 = 4'h4,
    CBU_Q4 = 4'h8
  } cbu_phase_t;

  typedef enum logic [2:0] {
    CBU_EXEC = 3'h1,
    CBU_IDLE = 3'h2,
    CBU_HOLD = 3'h4
  } cbu_state_t;

  typedef struct packed {
    logic not_neg;
    logic no_ovf;
    logic nonzero;
  } cbu_decode_t;

  typedef struct packed {
    logic negative;
    logic overflow;
    logic zero;
  } cbu_flags_t;
endpackage

/* src/cbu_phase_gen.sv */
// Four-phase generator for the instruction clock of the branch unit.
// Assumes one clock; each instruction cycle is four consecutive clk_in cycles.
`include "cbu_defs.svh"
module cbu_phase_gen (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  output cbu_pkg::cbu_phase_t     phase_out
);
  cbu_pkg::cbu_phase_t phase_reg;
  cbu_pkg::cbu_phase_t phase_next;

  always_comb begin
    case (phase_reg)
      cbu_pkg::CBU_Q1: phase_next = cbu_pkg::CBU_Q2;
      cbu_pkg::CBU_Q2: phase_next = cbu_pkg::CBU_Q3;
      cbu_pkg::CBU_Q3: phase_next = cbu_pkg::CBU_Q4;
      cbu_pkg::CBU_Q4: phase_next = cbu_pkg::CBU_Q1;
      default:         phase_next = cbu_pkg::CBU_Q1;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_reg <= cbu_pkg::CBU_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign phase_out = phase_reg;

  AST_PHASE_ORDER: assert property (@(posedge clk_in) disable iff (rst_in)
    phase_reg == cbu_pkg::CBU_Q4 |=> phase_reg == cbu_pkg::CBU_Q1)
    else $error("phase did not wrap from Q4 to Q1");
endmodule

/* sim/cbu_branch_unit_bench.sv */
// Self-checking bench for the conditional branch unit: a behavioural model
// predicts the taken decision, target and timing of each branch word.
// Assumes cbu_defs.svh on the include path and the package compiled first.
`include "cbu_defs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, a, b); end end
module cbu_branch_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk_in = 1'b0;
  logic                rst_in = 1'b1;
  logic                valid_in = 1'b0;
  logic [15:0]         instr_in = 16'h0000;
  logic [20:0]         pc_inc_in = 21'h000000;
  cbu_pkg::cbu_flags_t flags_in = 3'h0;
  cbu_pkg::cbu_phase_t phase_out;
  logic                is_branch_out;
  logic                busy_out;
  logic                pc_write_out;
  logic [20:0]         pc_target_out;
  logic                done_out;
  logic                taken_out;
  int                  failures = 0;
  int                  check_count = 0;
  logic [3:0]          ops [3] = '{`CBU_OP_NOT_NEG, `CBU_OP_NO_OVF, `CBU_OP_NONZERO};

  always #5 clk_in = ~clk_in;

  cbu_branch_unit #(.PC_WIDTH(21)) dut (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .valid_in      (valid_in),
    .instr_in      (instr_in),
    .pc_inc_in     (pc_inc_in),
    .flags_in      (flags_in),
    .phase_out     (phase_out),
    .is_branch_out (is_branch_out),
    .busy_out      (busy_out),
    .pc_write_out  (pc_write_out),
    .pc_target_out (pc_target_out),
    .done_out      (done_out),
    .taken_out     (taken_out)
  );

  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Presents one word at the edge that opens phase one, then watches a fixed
  // window long enough for the two-cycle taken case.
  task automatic run_op(input logic [3:0] op, input logic [7:0] off, input logic [20:0] pc, input logic [2:0] fl);
    int n;
    int done_n;
    int busy_n;
    logic exp_br;
    logic exp_tk;
    logic seen_wr;
    logic [20:0] exp_tg;
    exp_br = (op == `CBU_OP_NOT_NEG) || (op == `CBU_OP_NO_OVF) || (op == `CBU_OP_NONZERO);
    exp_tk = (op == `CBU_OP_NOT_NEG) ? !fl[2] : (op == `CBU_OP_NO_OVF) ? !fl[1] : (op == `CBU_OP_NONZERO) ? !fl[0] : 1'b0;
    exp_tg = pc + {{12{off[7]}}, off, 1'b0};
    n = 0;
    while (!(phase_out === cbu_pkg::CBU_Q4 && busy_out === 1'b0)) begin
      @(posedge clk_in);
      #1;
      n++;
      if (n > 20) begin
        failures++;
        give_verdict();
      end
    end
    @(posedge clk_in);
    valid_in <= 1'b1;
    instr_in <= {`CBU_OP_PREFIX, op, off};
    pc_inc_in <= pc;
    flags_in <= fl;
    @(posedge clk_in);
    done_n = 0;
    busy_n = 0;
    seen_wr = 1'b0;
    for (n = 1; n <= 12; n++) begin
      @(posedge clk_in);
      if (n == 2) valid_in <= 1'b0;
      #1;
      if (n == 1) `CHK(is_branch_out, exp_br)
      if (n == 1) `CHK(phase_out, cbu_pkg::CBU_Q3)
      if (n == 1 && exp_br) `CHK(taken_out, exp_tk)
      if (busy_out === 1'b1) busy_n++;
      if (done_out === 1'b1 && done_n == 0) done_n = n;
      if (pc_write_out === 1'b1) begin
        seen_wr = 1'b1;
        `CHK(n, 3)
        `CHK(pc_target_out, exp_tg)
      end
    end
    `CHK(seen_wr, exp_tk)
    `CHK(busy_n, exp_tk ? 4 : 0)
    `CHK(done_n, exp_br ? (exp_tk ? 7 : 3) : 0)
  endtask

  initial begin
    void'($urandom(44956));
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    // Offset extremes, 7F on even and 80 on odd flag patterns, exercise sign extension at both ends.
    for (int i = 0; i < 3; i++) begin
      for (int f = 0; f < 8; f++) begin
        run_op(ops[i], (f % 2) ? 8'h80 : 8'h7F, 21'h000100, 3'(f));
      end
    end
    run_op(4'h3, 8'h10, 21'h000200, 3'h0);
    run_op(4'h4, 8'h10, 21'h000200, 3'h0);
    run_op(`CBU_OP_NONZERO, 8'hFF, 21'h000000, 3'h0);
    run_op(`CBU_OP_NOT_NEG, 8'h01, 21'h1FFFFE, 3'h0);
    for (int i = 0; i < 40; i++) begin
      run_op(ops[$urandom_range(2, 0)], 8'($urandom), 21'($urandom), 3'($urandom));
    end
    give_verdict();
  end
endmodule
